// *** core/dcsf_params.svh ***
`ifndef DCSF_PARAMS_SVH
`define DCSF_PARAMS_SVH

// Clock and status settle timing
`define DCSF_CLK_NS          100
`define DCSF_RQM_MAX_NS      12000
`define DCSF_RQM_MAX_CYC     (`DCSF_RQM_MAX_NS / `DCSF_CLK_NS)
`define DCSF_RQM_HOLD_CYC    7'h02
`define DCSF_GAP_W           7

// Recalibrate step limit
`define DCSF_RECAL_MAX_STEPS 8'hFF
`define DCSF_STEP_W          8

// Main status bit positions
`define DCSF_MSR_SEEK_LSB    0
`define DCSF_MSR_CB          4
`define DCSF_MSR_EXM         5
`define DCSF_MSR_DIO         6
`define DCSF_MSR_RQM         7

// Result status zero bit positions
`define DCSF_ST0_TC_MSB      7
`define DCSF_ST0_TC_LSB      6
`define DCSF_ST0_SE          5
`define DCSF_ST0_EC          4
`define DCSF_ST0_NR          3
`define DCSF_ST0_HS          2
`define DCSF_ST0_US_MSB      1
`define DCSF_ST0_US_LSB      0

// Result status one bit positions
`define DCSF_ST1_EN          7
`define DCSF_ST1_UNUSED_HI   6
`define DCSF_ST1_DE          5
`define DCSF_ST1_OR          4
`define DCSF_ST1_UNUSED_LO   3
`define DCSF_ST1_ND          2
`define DCSF_ST1_NW          1

// Termination codes, reset values, result length
`define DCSF_TC_NORMAL       2'h0
`define DCSF_TC_ABNORMAL     2'h1
`define DCSF_TC_INVALID      2'h2
`define DCSF_STATUS_RESET    8'h00
`define DCSF_RESULT_LAST     1'h1

`endif

// *** core/dcsf_pin_sync.sv ***
`timescale 1ns/1ns

module dcsf_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Asynchronous pins in, synchronised copy out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcsf_sync_t;

    dcsf_sync_t q_r;
    dcsf_sync_t q_nxt;

    generate
        if (W < 1) begin : g_chk
            $error("dcsf_pin_sync: W must be at least 1");
        end
    endgenerate

    // Two-stage chain; first stage feeds only the second
    always_comb begin
        q_nxt    = q_r;
        q_nxt.s1 = pin_in;
        q_nxt.s2 = q_r.s1;
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign pin_sync = q_r.s2;

endmodule

// *** core/dcsf_pkg.sv ***
`include "dcsf_params.svh"

package dcsf_pkg;

    // Controller phase, one-hot
    typedef enum logic [3:0] {
        DCSF_IDLE = 4'h1,
        DCSF_CMD  = 4'h2,
        DCSF_EXEC = 4'h4,
        DCSF_RES  = 4'h8
    } dcsf_phase_t;

    // Whole state of the status core
    typedef struct packed {
        dcsf_phase_t              phase;
        logic [7:0]               st0;
        logic [7:0]               st1;
        logic                     res_idx;
        logic [`DCSF_GAP_W-1:0]   gap;
        logic [7:0]               dout;
        logic                     oe_n;
        logic                     rd_prev;
        logic                     rd_a0;
        logic                     wr_prev;
        logic [`DCSF_STEP_W-1:0]  steps;
        logic                     ec;
        logic                     byte_wr;
        logic [7:0]               byte_data;
        logic                     exec_start;
        logic                     reject;
    } dcsf_core_t;

endpackage

// *** core/dcsf_seek_flags.sv ***
`timescale 1ns/1ns

module dcsf_seek_flags #(
    parameter int DRIVES = 4
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Seek events per drive
    input  wire logic [DRIVES-1:0] seek_start,
    input  wire logic [DRIVES-1:0] seek_done,
    // Busy flags
    output logic      [DRIVES-1:0] seek_busy
);

    typedef struct packed {
        logic [DRIVES-1:0] busy;
    } dcsf_seek_t;

    dcsf_seek_t q_r;
    dcsf_seek_t q_nxt;

    generate
        if (DRIVES < 1) begin : g_chk
            $error("dcsf_seek_flags: DRIVES must be at least 1");
        end
    endgenerate

    // Per-drive busy flag, a new seek wins over completion
    generate
        for (genvar i = 0; i < DRIVES; i++) begin : g_drv
            always_comb begin
                q_nxt.busy[i] = (q_r.busy[i] && !seek_done[i]) || seek_start[i];
            end
        end
    endgenerate

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign seek_busy = q_r.busy;

    property p_seek_busy;
        @(posedge clk) disable iff (srst)
        (seek_start != '0) |=> ((seek_busy & $past(seek_start)) == $past(seek_start));
    endproperty
    a_seek_busy: assert property (p_seek_busy) else $error("seek busy not set after seek start");

endmodule

// *** core/dcsf_status_core.sv ***
`timescale 1ns/1ns
`include "dcsf_params.svh"

module dcsf_status_core
    import dcsf_pkg::*;
#(
    parameter int DRIVES = 4
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Host peripheral bus pins
    input  wire logic              host_cs_n,
    input  wire logic              host_rd_n,
    input  wire logic              host_wr_n,
    input  wire logic              host_a0,
    input  wire logic [7:0]        host_data_in,
    output logic      [7:0]        host_data_out,
    output logic                   host_data_oe_n,
    // Command sequencer handshake
    input  wire logic              cmd_complete,
    input  wire logic              cmd_is_rw,
    input  wire logic              dma_mode,
    input  wire logic              exec_xfer_req,
    input  wire logic              exec_to_host,
    output logic                   cmd_byte_valid,
    output logic      [7:0]        cmd_byte,
    output logic                   exec_start,
    output logic                   cmd_reject,
    // Termination report from the sequencer
    input  wire logic              exec_done,
    input  wire logic [1:0]        termination_code,
    input  wire logic              seek_end,
    input  wire logic              head_at_interrupt,
    input  wire logic [1:0]        unit_number,
    input  wire logic              end_of_cylinder,
    input  wire logic              crc_data_error,
    input  wire logic              overrun_error,
    input  wire logic              nd_sector_missing,
    input  wire logic              nd_id_unreadable,
    input  wire logic              nd_track_start_missing,
    input  wire logic              write_protected_error,
    // Seek and recalibrate activity
    input  wire logic [DRIVES-1:0] seek_start,
    input  wire logic [DRIVES-1:0] seek_done,
    input  wire logic              recal_active,
    input  wire logic              step_pulse,
    input  wire logic              track0_pin,
    output logic      [DRIVES-1:0] seek_busy
);

    localparam int RQM_BOUND = `DCSF_RQM_MAX_CYC;

    dcsf_core_t  q_r;
    dcsf_core_t  q_nxt;
    logic [12:0] pins_sync;
    logic        cs_n_s;
    logic        rd_n_s;
    logic        wr_n_s;
    logic        a0_s;
    logic [7:0]  din_s;
    logic        track0_s;
    logic        rd_act;
    logic        wr_act;
    logic        any_seek;
    logic        request_for_master;
    logic        transfer_direction;
    logic        execution_mode_flag;
    logic [7:0]  main_status_reg;
    logic [7:0]  data_byte;
    logic [7:0]  st0_cap;
    logic [7:0]  st1_cap;

    generate
        if (DRIVES != 4) begin : g_chk
            $error("dcsf_status_core: two-bit unit field serves exactly four drives");
        end
        if (`DCSF_RQM_MAX_CYC < 2) begin : g_chk_rqm
            $error("dcsf_status_core: settle bound shorter than hold time");
        end
    endgenerate

    // Host pins and track zero pass two flip-flops; strobes travel inverted so a flushed chain reads idle
    dcsf_pin_sync #(
        .W (13)
    ) u_sync (
        .clk      (clk),
        .srst     (srst),
        .pin_in   ({track0_pin, host_cs_n, host_rd_n, host_wr_n, host_a0, host_data_in} ^ 13'h0E00),
        .pin_sync (pins_sync)
    );

    assign {track0_s, cs_n_s, rd_n_s, wr_n_s, a0_s, din_s} = pins_sync ^ 13'h0E00;

    // Per-drive seek busy flags
    dcsf_seek_flags #(
        .DRIVES (DRIVES)
    ) u_seek (
        .clk        (clk),
        .srst       (srst),
        .seek_start (seek_start),
        .seek_done  (seek_done),
        .seek_busy  (seek_busy)
    );

    // Strobe levels and main status bits
    always_comb begin
        rd_act   = !cs_n_s && !rd_n_s;
        wr_act   = !cs_n_s && !wr_n_s;
        any_seek = |seek_busy;
        execution_mode_flag      = (q_r.phase == DCSF_EXEC) && !dma_mode;
        transfer_direction      = (q_r.phase == DCSF_RES) || ((q_r.phase == DCSF_EXEC) && exec_to_host);
        request_for_master      = 1'b0;
        case (q_r.phase)
            DCSF_IDLE, DCSF_CMD, DCSF_RES: begin
                request_for_master = (q_r.gap == '0);
            end
            DCSF_EXEC: begin
                request_for_master = exec_xfer_req && !dma_mode;
            end
            default: begin
                request_for_master = 1'b0;
            end
        endcase
        main_status_reg                               = `DCSF_STATUS_RESET;
        main_status_reg[`DCSF_MSR_SEEK_LSB +: DRIVES] = seek_busy;
        main_status_reg[`DCSF_MSR_CB]                 = (q_r.phase != DCSF_IDLE);
        main_status_reg[`DCSF_MSR_EXM]                = execution_mode_flag;
        main_status_reg[`DCSF_MSR_DIO]                = transfer_direction;
        main_status_reg[`DCSF_MSR_RQM]                = request_for_master;
    end

    // Result bytes visible only in the result phase
    always_comb begin
        data_byte = `DCSF_STATUS_RESET;
        if (q_r.phase == DCSF_RES) begin
            data_byte = (q_r.res_idx == `DCSF_RESULT_LAST) ? q_r.st1 : q_r.st0;
        end
    end

    // Result status images built at termination
    always_comb begin
        st0_cap                                         = `DCSF_STATUS_RESET;
        st0_cap[`DCSF_ST0_TC_MSB:`DCSF_ST0_TC_LSB]      = termination_code;
        st0_cap[`DCSF_ST0_SE]                           = seek_end;
        st0_cap[`DCSF_ST0_EC]                           = q_r.ec;
        st0_cap[`DCSF_ST0_NR]                           = 1'b0;
        st0_cap[`DCSF_ST0_HS]                           = head_at_interrupt;
        st0_cap[`DCSF_ST0_US_MSB:`DCSF_ST0_US_LSB]      = unit_number;
        st1_cap                                         = `DCSF_STATUS_RESET;
        st1_cap[`DCSF_ST1_EN]                           = end_of_cylinder;
        st1_cap[`DCSF_ST1_UNUSED_HI]                    = 1'b0;
        st1_cap[`DCSF_ST1_UNUSED_LO]                    = 1'b0;
        st1_cap[`DCSF_ST1_DE]                           = crc_data_error;
        st1_cap[`DCSF_ST1_OR]                           = overrun_error;
        st1_cap[`DCSF_ST1_ND]                           = nd_sector_missing || nd_id_unreadable
                                                          || nd_track_start_missing;
        st1_cap[`DCSF_ST1_NW]                           = write_protected_error;
    end

    // Next-state logic
    always_comb begin
        q_nxt            = q_r;
        q_nxt.byte_wr    = 1'b0;
        q_nxt.exec_start = 1'b0;
        q_nxt.reject     = 1'b0;
        q_nxt.rd_prev    = rd_act;
        q_nxt.wr_prev    = wr_act;
        if (q_r.gap != '0) begin
            q_nxt.gap = q_r.gap - `DCSF_RQM_HOLD_CYC + `DCSF_GAP_W'(1);
        end

        // Recalibrate step count and equipment check
        if (!recal_active) begin
            q_nxt.steps = '0;
        end else if (step_pulse && !track0_s && (q_r.steps != `DCSF_RECAL_MAX_STEPS)) begin
            q_nxt.steps = q_r.steps + `DCSF_STEP_W'(1);
            if (q_r.steps == (`DCSF_RECAL_MAX_STEPS - `DCSF_STEP_W'(1))) begin
                q_nxt.ec = 1'b1;
            end
        end

        // Host read: drive on leading edge, release on trailing edge
        if (rd_act && !q_r.rd_prev) begin
            q_nxt.dout  = a0_s ? data_byte : main_status_reg;
            q_nxt.rd_a0 = a0_s;
            q_nxt.oe_n  = 1'b0;
        end
        if (!rd_act && q_r.rd_prev) begin
            q_nxt.oe_n = 1'b1;
            if (q_r.rd_a0 && (q_r.phase == DCSF_RES) && (q_r.gap == '0)) begin
                q_nxt.gap = `DCSF_RQM_HOLD_CYC;
                if (q_r.res_idx == `DCSF_RESULT_LAST) begin
                    q_nxt.phase   = DCSF_IDLE;
                    q_nxt.res_idx = 1'b0;
                end else begin
                    q_nxt.res_idx = `DCSF_RESULT_LAST;
                end
            end
        end

        // Byte follows the bus while the strobe is low; host may change it as the strobe rises
        if (wr_act && a0_s && (q_r.gap == '0)
            && ((q_r.phase == DCSF_IDLE) || (q_r.phase == DCSF_CMD))) begin
            q_nxt.byte_data = din_s;
        end

        // Host write of a command byte on trailing edge
        if (!wr_act && q_r.wr_prev && a0_s && (q_r.gap == '0)
            && ((q_r.phase == DCSF_IDLE) || (q_r.phase == DCSF_CMD))) begin
            q_nxt.byte_wr   = 1'b1;
            q_nxt.phase     = DCSF_CMD;
            q_nxt.gap       = `DCSF_RQM_HOLD_CYC;
        end

        // Phase sequencing
        case (q_r.phase)
            DCSF_IDLE: begin
                q_nxt.res_idx = 1'b0;
            end
            DCSF_CMD: begin
                if (cmd_complete) begin
                    if (cmd_is_rw && any_seek) begin
                        q_nxt.reject = 1'b1;
                        q_nxt.st0    = `DCSF_STATUS_RESET;
                        q_nxt.st0[`DCSF_ST0_TC_MSB:`DCSF_ST0_TC_LSB] = `DCSF_TC_INVALID;
                        q_nxt.st1    = `DCSF_STATUS_RESET;
                        q_nxt.phase  = DCSF_RES;
                        q_nxt.gap    = '0;
                    end else begin
                        q_nxt.exec_start = 1'b1;
                        q_nxt.phase      = DCSF_EXEC;
                    end
                end
            end
            DCSF_EXEC: begin
                if (exec_done) begin
                    q_nxt.st0     = st0_cap;
                    q_nxt.st1     = st1_cap;
                    q_nxt.ec      = q_nxt.ec && !q_r.ec; // A step in this cycle sets it only if it was clear
                    q_nxt.phase   = DCSF_RES;
                    q_nxt.res_idx = 1'b0;
                    q_nxt.gap     = '0;
                end
            end
            DCSF_RES: begin
                q_nxt.st0 = q_r.st0;
            end
            default: begin
                q_nxt.phase = DCSF_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q_r       <= '0;
            q_r.phase <= DCSF_IDLE;
            q_r.oe_n  <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs from flip-flops
    assign host_data_out  = q_r.dout;
    assign host_data_oe_n = q_r.oe_n;
    assign cmd_byte_valid = q_r.byte_wr;
    assign cmd_byte       = q_r.byte_data;
    assign exec_start     = q_r.exec_start;
    assign cmd_reject     = q_r.reject;

    // Checks
    property p_rw_refused;
        @(posedge clk) disable iff (srst)
        ((q_r.phase == DCSF_CMD) && cmd_complete && cmd_is_rw && any_seek)
            |=> (cmd_reject && !exec_start && (q_r.phase == DCSF_RES));
    endproperty
    a_rw_refused: assert property (p_rw_refused) else $error("read/write accepted during seek");

    property p_busy_blocks;
        @(posedge clk) disable iff (srst)
        (cmd_complete && (q_r.phase != DCSF_CMD)) |=> !exec_start;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("command started while busy");

    property p_exm_only_exec;
        @(posedge clk) disable iff (srst)
        main_status_reg[`DCSF_MSR_EXM] |-> (!dma_mode && (q_r.phase == DCSF_EXEC) && main_status_reg[`DCSF_MSR_CB]);
    endproperty
    a_exm_only_exec: assert property (p_exm_only_exec) else $error("execution bit outside execution");

    property p_exm_clears;
        @(posedge clk) disable iff (srst)
        ((q_r.phase == DCSF_EXEC) && exec_done) |=> (!main_status_reg[`DCSF_MSR_EXM] && main_status_reg[`DCSF_MSR_DIO]);
    endproperty
    a_exm_clears: assert property (p_exm_clears) else $error("execution bit stuck after end");

    property p_dio_result;
        @(posedge clk) disable iff (srst)
        (q_r.phase == DCSF_RES) |-> main_status_reg[`DCSF_MSR_DIO];
    endproperty
    a_dio_result: assert property (p_dio_result) else $error("direction wrong in result phase");

    property p_rqm_settle;
        @(posedge clk) disable iff (srst)
        ($fell(request_for_master) && (q_r.phase != DCSF_EXEC)) |-> ##[1:RQM_BOUND] (request_for_master || (q_r.phase == DCSF_EXEC));
    endproperty
    a_rqm_settle: assert property (p_rqm_settle) else $error("ready not back within settle time");

    property p_nr_zero;
        @(posedge clk) disable iff (srst)
        !q_r.st0[`DCSF_ST0_NR] && !q_r.st1[`DCSF_ST1_UNUSED_HI] && !q_r.st1[`DCSF_ST1_UNUSED_LO];
    endproperty
    a_nr_zero: assert property (p_nr_zero) else $error("constant-zero status bit set");

    property p_result_hold;
        @(posedge clk) disable iff (srst)
        ((q_r.phase == DCSF_RES) && $past(q_r.phase == DCSF_RES)) |-> ($stable(q_r.st0) && $stable(q_r.st1));
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result status changed in result phase");

    property p_result_gated;
        @(posedge clk) disable iff (srst)
        (rd_act && !q_r.rd_prev && a0_s && (q_r.phase != DCSF_RES)) |=> (host_data_out == 8'h00);
    endproperty
    a_result_gated: assert property (p_result_gated) else $error("result byte leaked outside result phase");

endmodule

// *** test/dcsf_host_model.sv ***
`timescale 1ns/1ns

module dcsf_host_model (
    // Clock
    input  wire logic       clk,
    // Bus pins toward the device
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic            a0,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    int last_polls;

    // Idle bus levels
    initial begin
        cs_n  = 1'b1;
        rd_n  = 1'b1;
        wr_n  = 1'b1;
        a0    = 1'b0;
        wdata = 8'hA5;
    end

    // One strobe, five cycles low and four high; read data taken before release
    task automatic xfer(input logic rd, input logic sel, input logic [7:0] wd, output logic [7:0] rv);
        @(negedge clk);
        cs_n  = 1'b0;
        a0    = sel;
        wdata = wd;
        rd_n  = !rd;
        wr_n  = rd;
        repeat (5) @(negedge clk);
        rv    = rdata;
        cs_n  = 1'b1;
        rd_n  = 1'b1;
        wr_n  = 1'b1;
        wdata = ~wd; // Released bus must not keep the old byte
        repeat (4) @(negedge clk);
    endtask

    // Poll main status until ready in the wanted direction, bounded
    task automatic poll(input logic dir);
        logic [7:0] v;
        last_polls = 0;
        v = 8'h00;
        while (!(v[7] === 1'b1 && v[6] === dir) && last_polls < 20) begin
            xfer(1'b1, 1'b0, 8'h00, v);
            last_polls++;
        end
    endtask

    // Data register write after handshake
    task automatic put(input logic [7:0] b);
        logic [7:0] v;
        poll(1'b0);
        xfer(1'b0, 1'b1, b, v);
    endtask

    // Data register read after handshake
    task automatic get(output logic [7:0] b);
        poll(1'b1);
        xfer(1'b1, 1'b1, 8'h00, b);
    endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        a0;
    logic [7:0]  hd_in;
    logic [7:0]  hd_out;
    logic        oe_n;
    logic        cmd_complete = 1'b0;
    logic        cmd_is_rw = 1'b0;
    logic        dma_mode = 1'b0;
    logic        xfer_req = 1'b0;
    logic        to_host = 1'b0;
    logic        cbv;
    logic [7:0]  cbyte;
    logic        xs;
    logic        rej;
    logic        exec_done = 1'b0;
    logic [1:0]  tc = 2'h0;
    logic [10:0] fl = 11'h000;
    logic [3:0]  sk_start = 4'h0;
    logic [3:0]  sk_done = 4'h0;
    logic [3:0]  busy;
    logic        recal = 1'b0;
    logic        step = 1'b0;
    logic        trk0 = 1'b0;
    logic [7:0]  v;
    int          n_errors = 0;
    int          check_count = 0;
    int          n_cbv = 0;
    int          n_xs = 0;
    int          n_rej = 0;
    int          n_oe = 0;

    // Clock
    always #50 clk = ~clk;

    dcsf_host_model dcsf_host_model_inst (
        .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .wdata(hd_in), .rdata(hd_out)
    );

    dcsf_status_core #(.DRIVES(4)) dcsf_status_core_inst (
        .clk(clk), .srst(srst), .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
        .host_a0(a0), .host_data_in(hd_in), .host_data_out(hd_out), .host_data_oe_n(oe_n),
        .cmd_complete(cmd_complete), .cmd_is_rw(cmd_is_rw), .dma_mode(dma_mode),
        .exec_xfer_req(xfer_req), .exec_to_host(to_host), .cmd_byte_valid(cbv),
        .cmd_byte(cbyte), .exec_start(xs), .cmd_reject(rej), .exec_done(exec_done),
        .termination_code(tc), .seek_end(fl[10]), .head_at_interrupt(fl[9]),
        .unit_number(fl[8:7]), .end_of_cylinder(fl[6]), .crc_data_error(fl[5]),
        .overrun_error(fl[4]), .nd_sector_missing(fl[3]), .nd_id_unreadable(fl[2]),
        .nd_track_start_missing(fl[1]), .write_protected_error(fl[0]),
        .seek_start(sk_start), .seek_done(sk_done), .recal_active(recal),
        .step_pulse(step), .track0_pin(trk0), .seek_busy(busy)
    );

    // Pulse counters on the sequencer side, and a count of cycles with the host output enable low
    always @(posedge clk) begin
        if (cbv === 1'b1) n_cbv++;
        if (xs === 1'b1) n_xs++;
        if (rej === 1'b1) n_rej++;
        if (oe_n === 1'b0) n_oe++;
    end

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic print_verdict;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main status read and compare
    task automatic main_is(input logic [7:0] exp);
        dcsf_host_model_inst.xfer(1'b1, 1'b0, 8'h00, v);
        chk(v, exp);
    endtask

    // Command byte then completion strobe
    task automatic issue(input logic [7:0] b, input logic rw);
        dcsf_host_model_inst.put(b);
        chk({7'h00, dcsf_host_model_inst.last_polls < 14}, 8'h01);
        chk(cbyte, b);
        @(negedge clk);
        cmd_complete = 1'b1;
        cmd_is_rw    = rw;
        @(negedge clk);
        cmd_complete = 1'b0;
        @(negedge clk);
    endtask

    // Full command with termination report and both result reads
    task automatic run_cmd(input logic dma, input logic [1:0] code, input logic [10:0] f, input logic ec);
        int b0;
        b0 = n_xs;
        dma_mode = dma;
        issue(f[7:0], 1'b0);
        chk(8'(n_xs - b0), 8'h01);
        main_is(dma ? 8'h10 : 8'h30);
        if (!dma) begin
            xfer_req = 1'b1;
            to_host  = 1'b1;
            main_is(8'hF0);
            xfer_req = 1'b0;
            to_host  = 1'b0;
        end
        @(negedge clk);
        exec_done = 1'b1;
        tc = code;
        fl = f;
        @(negedge clk);
        exec_done = 1'b0;
        fl = ~f; // Late changes must not reach the captured result
        main_is(8'hD0);
        dcsf_host_model_inst.get(v);
        chk(v, {code, f[10], ec, 1'b0, f[9:7]});
        dcsf_host_model_inst.get(v);
        chk(v, {f[6], 1'b0, f[5:4], 1'b0, |f[3:1], f[0], 1'b0});
        main_is(8'h80);
    endtask

    // Recalibrate stepping with track zero absent
    task automatic steps(input int n);
        recal = 1'b0;
        @(negedge clk);
        recal = 1'b1;
        repeat (n) begin
            @(negedge clk);
            step = 1'b1;
            @(negedge clk);
            step = 1'b0;
        end
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        print_verdict();
    end

    // Test sequence
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h00, oe_n}, 8'h01);
        @(negedge clk);
        cmd_complete = 1'b1; // Ignored outside the command phase
        @(negedge clk);
        cmd_complete = 1'b0;
        main_is(8'h80);
        dcsf_host_model_inst.xfer(1'b1, 1'b1, 8'h00, v);
        chk(v, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            sk_start = 4'h1 << i;
            @(negedge clk);
            sk_start = 4'h0;
            chk({4'h0, busy}, 8'((2 << i) - 1));
        end
        main_is(8'h8F);
        @(negedge clk);
        sk_done = 4'hB;
        @(negedge clk);
        sk_done = 4'h0;
        @(negedge clk);
        chk({4'h0, busy}, 8'h04);
        issue(8'h46, 1'b1);
        chk(8'(n_rej), 8'h01);
        chk(8'(n_xs), 8'h00);
        main_is(8'hD4);
        dcsf_host_model_inst.get(v);
        chk({v[7:6], 6'h00}, 8'h80);
        dcsf_host_model_inst.get(v);
        chk(v, 8'h00);
        main_is(8'h84);
        @(negedge clk);
        sk_done = 4'h4;
        @(negedge clk);
        sk_done = 4'h0;
        run_cmd(1'b0, 2'h0, 11'h555, 1'b0);
        run_cmd(1'b1, 2'h1, 11'h2AA, 1'b0);
        run_cmd(1'b0, 2'h2, 11'h7FF, 1'b0);
        steps(255);
        run_cmd(1'b0, 2'h1, 11'h0A9, 1'b1);
        steps(254);
        run_cmd(1'b0, 2'h0, 11'h000, 1'b0);
        chk({7'h00, n_oe > 0}, 8'h01);
        chk(8'(n_cbv), 8'h06);
        print_verdict();
    end
endmodule
